// [mqrp_read_port.sv]
// Read-port queue select, FIRST_WORD_FALLTHROUGH output pipeline and almost-empty flag bus.
// Assumes queue storage outside answers combinationally on queueRdData.
`timescale 1ns/100ps
`default_nettype none
module mqrp_read_port (
	input  wire logic                          core_clk,
	input  wire logic                          rst_n,
	input  wire logic                          serialMode,
	input  wire logic                          serialClk,
	input  wire logic                          serialIn,
	input  wire logic                          serial_load_enable_n,
	input  wire logic                          read_queue_select_enable,
	input  wire logic [mqrp_pkg::SEL_W-1:0]    read_select_bus,
	input  wire logic                          flag_quadrant_strobe,
	input  wire logic                          readStrobe_n,
	input  wire logic                          polledMode,
	input  wire logic                          expansion_token_in,
	input  wire logic [mqrp_pkg::QUEUES-1:0]   queueEmpty,
	input  wire logic [mqrp_pkg::QUEUES-1:0]   queueAlmostEmpty,
	input  wire logic [mqrp_pkg::DATA_W-1:0]   queueRdData,
	output logic [mqrp_pkg::QSEL_W-1:0]        queueRdIdx,
	output logic                               queueRdPop,
	output logic [mqrp_pkg::DATA_W-1:0]        readData,
	output logic                               output_valid_n,
	output logic                               almost_empty_flag_n,
	output logic [mqrp_pkg::FLAG_W-1:0]        almost_empty_flag_bus,
	output logic                               flag_bus_sync,
	output logic                               expansion_token_out,
	output logic                               serial_done_out_n,
	output logic [mqrp_pkg::QSEL_W-1:0]        activeQueue
);
	typedef enum logic [1:0] {
		MQRP_IDLE  = 2'b00,
		MQRP_DRAIN = 2'b01,
		MQRP_FALL  = 2'b11
	} mqrp_state_t;

	// Device match on top bits
	function automatic logic isMine(input logic [mqrp_pkg::SEL_W-1:0] sel,
	                                input logic [mqrp_pkg::DEV_W-1:0] id);
		isMine = sel[mqrp_pkg::DEV_LSB +: mqrp_pkg::DEV_W] == id;
	endfunction : isMine

	logic [mqrp_pkg::DEV_W-1:0] deviceId;
	logic                       progDone;
	logic                       doneN;

	mqrp_cfg_shift u_cfg (
		.core_clk             (core_clk),
		.rst_n                (rst_n),
		.serialMode           (serialMode),
		.serialClk            (serialClk),
		.serialIn             (serialIn),
		.serial_load_enable_n (serial_load_enable_n),
		.deviceId             (deviceId),
		.progDone             (progDone),
		.serial_done_out_n    (doneN)
	);

	mqrp_state_t                 state;
	mqrp_state_t                 next_state;
	mqrp_pkg::mqrp_sel_t         sel;
	logic [mqrp_pkg::QSEL_W-1:0] prevQueue;
	logic [mqrp_pkg::QUAD_W-1:0] quad;
	logic [mqrp_pkg::QUAD_W-1:0] pollQuad;
	logic                        owner;
	logic                        tokenSync;
	logic [mqrp_pkg::QSEL_W-1:0] next_queue;
	logic [mqrp_pkg::QSEL_W-1:0] next_prevQueue;
	logic [mqrp_pkg::QUAD_W-1:0] next_quad;
	logic [mqrp_pkg::QUAD_W-1:0] next_pollQuad;
	logic                        next_owner;
	logic [mqrp_pkg::QSEL_W-1:0] next_rdIdx;
	logic                        next_pop;
	logic [mqrp_pkg::DATA_W-1:0] next_data;
	logic                        next_ovN;
	logic                        next_almost_empty_flag_bus;
	logic [mqrp_pkg::FLAG_W-1:0] next_bus;
	logic                        next_sync;
	logic [mqrp_pkg::QUAD_W-1:0] showQuad;
	logic                        selHit;
	logic                        quadHit;
	logic                        want;

	always_comb begin
		selHit = progDone && read_queue_select_enable && isMine(read_select_bus, deviceId);
		quadHit = flag_quadrant_strobe && isMine(read_select_bus, deviceId);
		next_queue     = sel.queue;
		next_prevQueue = prevQueue;
		next_state     = state;
		next_owner     = owner;
		// Selection ignores the read strobe
		if (selHit) begin
			next_queue     = read_select_bus[mqrp_pkg::QSEL_LSB +: mqrp_pkg::QSEL_W];
			next_prevQueue = sel.queue;
			next_state     = MQRP_DRAIN;
			next_owner     = 1'b1;
		end else if (progDone && read_queue_select_enable) begin
			// Another device addressed: release output ownership
			next_owner = 1'b0;
		end else begin
			case (state)
				MQRP_DRAIN: next_state = MQRP_FALL;
				MQRP_FALL:  next_state = MQRP_IDLE;
				MQRP_IDLE:  next_state = MQRP_IDLE;
				default:    next_state = MQRP_IDLE;
			endcase
		end
		// Pop runs one edge ahead of the data: old queue pops on the select edge,
		// the new one on the next, so each word lands on the edge the host expects
		want = 1'b0;
		next_rdIdx = next_queue;
		case (next_state)
			MQRP_DRAIN: begin
				next_rdIdx = next_prevQueue;
				want       = 1'b1;
			end
			MQRP_FALL: begin
				next_rdIdx = next_queue;
				want       = 1'b1;
			end
			default: begin
				next_rdIdx = next_queue;
				want       = !readStrobe_n;
			end
		endcase
		next_pop  = next_owner && want && !queueEmpty[next_rdIdx];
		// Store answers for the registered index, so take its word as it pops
		next_data = queueRdPop ? queueRdData : readData;
		next_ovN  = !(next_owner && !queueEmpty[next_rdIdx]);
		next_almost_empty_flag_bus = !queueAlmostEmpty[sel.queue];
		// Quadrant latch ignores bits 4:2
		next_quad = quadHit ? read_select_bus[mqrp_pkg::QUAD_W-1:0] : quad;
		next_pollQuad = pollQuad + 2'h1;
		showQuad  = polledMode ? pollQuad : quad;
		next_bus  = ~queueAlmostEmpty[showQuad*mqrp_pkg::FLAG_W +: mqrp_pkg::FLAG_W];
		next_sync = polledMode && (pollQuad == mqrp_pkg::QUAD_RST);
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state                 <= MQRP_IDLE;
			sel                   <= '0;
			prevQueue             <= mqrp_pkg::QUEUE_RST;
			quad                  <= mqrp_pkg::QUAD_RST;
			pollQuad              <= mqrp_pkg::QUAD_RST;
			owner                 <= 1'b1;
			tokenSync             <= 1'b0;
			queueRdIdx            <= mqrp_pkg::QUEUE_RST;
			queueRdPop            <= 1'b0;
			readData              <= 18'h0_0000;
			output_valid_n        <= 1'b1;
			almost_empty_flag_n   <= 1'b1;
			almost_empty_flag_bus <= 8'hFF;
			flag_bus_sync         <= 1'b0;
			expansion_token_out   <= 1'b0;
			serial_done_out_n     <= 1'b1;
			activeQueue           <= mqrp_pkg::QUEUE_RST;
		end else begin
			state                 <= next_state;
			sel.queue             <= next_queue;
			sel.dev               <= deviceId;
			prevQueue             <= next_prevQueue;
			quad                  <= next_quad;
			pollQuad              <= next_pollQuad;
			owner                 <= next_owner;
			tokenSync             <= expansion_token_in;
			queueRdIdx            <= next_rdIdx;
			queueRdPop            <= next_pop;
			readData              <= next_data;
			output_valid_n        <= next_ovN;
			almost_empty_flag_n   <= next_almost_empty_flag_bus;
			almost_empty_flag_bus <= next_bus;
			flag_bus_sync         <= next_sync;
			// Token passes on when this device gives up the read bus
			expansion_token_out   <= owner && !next_owner;
			serial_done_out_n     <= doneN;
			activeQueue           <= next_queue;
		end
	end
endmodule : mqrp_read_port
`default_nettype wire

// [mqrp_pkg.sv]
// Constants and carrier types for the multi-queue read-port select block.
// Assumes one clock (core_clk) stands in for the free-running read clock.
package mqrp_pkg;
	localparam int QUEUES      = 32;
	localparam int QUAD_CNT    = 4;
	localparam int FLAG_W      = 8;
	localparam int DATA_W      = 18;
	localparam int SEL_W       = 8;
	localparam int QSEL_LSB    = 0;
	localparam int QSEL_W      = 5;
	localparam int DEV_LSB     = 5;
	localparam int DEV_W       = 3;
	localparam int QUAD_W      = 2;
	localparam int CFG_BITS    = 8;
	localparam int CFG_CNT_W   = 4;
	localparam logic [QSEL_W-1:0] QUEUE_RST = 5'h00;
	localparam logic [QUAD_W-1:0] QUAD_RST  = 2'h0;
	localparam logic [DEV_W-1:0]  DEV_ID_RST = 3'h0;

	typedef struct packed {
		logic [DEV_W-1:0]  dev;
		logic [QSEL_W-1:0] queue;
	} mqrp_sel_t;

	typedef struct packed {
		logic              valid;
		logic [QSEL_W-1:0] queue;
		logic [DATA_W-1:0] data;
	} mqrp_word_t;
endpackage : mqrp_pkg

// [mqrp_cfg_shift.sv]
// Serial configuration loader: shift register on the core clock, fed by
// synchronised serial clock, data and load enable pins.
`timescale 1ns/100ps
`default_nettype none
module mqrp_cfg_shift (
	input  wire logic                       core_clk,
	input  wire logic                       rst_n,
	input  wire logic                       serialMode,
	input  wire logic                       serialClk,
	input  wire logic                       serialIn,
	input  wire logic                       serial_load_enable_n,
	output logic [mqrp_pkg::DEV_W-1:0]      deviceId,
	output logic                            progDone,
	output logic                            serial_done_out_n
);
	logic [2:0] s1;
	logic [2:0] s2;
	logic       clkPrev;
	logic [mqrp_pkg::CFG_BITS-1:0]  shiftReg;
	logic [mqrp_pkg::CFG_CNT_W-1:0] bitCnt;
	logic [mqrp_pkg::CFG_BITS-1:0]  next_shiftReg;
	logic [mqrp_pkg::CFG_CNT_W-1:0] next_bitCnt;
	logic next_progDone;
	logic next_doneN;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1      <= 3'h7;
			s2      <= 3'h7;
			clkPrev <= 1'b1;
		end else begin
			s1      <= {serialClk, serialIn, serial_load_enable_n};
			s2      <= s1;
			clkPrev <= s2[2];
		end
	end

	always_comb begin
		next_shiftReg = shiftReg;
		next_bitCnt   = bitCnt;
		next_progDone = progDone;
		// Default configuration counts as programmed at once
		if (!serialMode) begin
			next_progDone = 1'b1;
		end else if (!progDone && !s2[0] && s2[2] && !clkPrev) begin
			next_shiftReg = {shiftReg[mqrp_pkg::CFG_BITS-2:0], s2[1]};
			next_bitCnt   = bitCnt + 4'h1;
			if (bitCnt == 4'(mqrp_pkg::CFG_BITS - 1)) begin
				next_progDone = 1'b1;
			end
		end
		// Done output follows load enable once programmed
		next_doneN = progDone ? s2[0] : 1'b1;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			shiftReg          <= 8'h00;
			bitCnt            <= 4'h0;
			progDone          <= 1'b0;
			serial_done_out_n <= 1'b1;
		end else begin
			shiftReg          <= next_shiftReg;
			bitCnt            <= next_bitCnt;
			progDone          <= next_progDone;
			serial_done_out_n <= next_doneN;
		end
	end

	assign deviceId = serialMode ? shiftReg[mqrp_pkg::DEV_W-1:0] : mqrp_pkg::DEV_ID_RST;
endmodule : mqrp_cfg_shift
`default_nettype wire

// [mqrp_read_port_checker.sv]
// Concurrent checks on the read-port select block, watching its ports only.
// Assumes device id 0 and a queue store that never runs empty.
`timescale 1ns/100ps
`default_nettype none
module mqrp_read_port_checker (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        read_queue_select_enable,
	input wire logic [7:0]  read_select_bus,
	input wire logic        flag_quadrant_strobe,
	input wire logic        polledMode,
	input wire logic        serial_load_enable_n,
	input wire logic [31:0] queueAlmostEmpty,
	input wire logic [17:0] queueRdData,
	input wire logic [4:0]  queueRdIdx,
	input wire logic        queueRdPop,
	input wire logic [17:0] readData,
	input wire logic [7:0]  almost_empty_flag_bus,
	input wire logic        flag_bus_sync,
	input wire logic        serial_done_out_n,
	input wire logic [4:0]  activeQueue
);
	logic take;
	assign take = read_queue_select_enable && read_select_bus[7:5] == 3'h0 && !serial_done_out_n;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_pop_old_queue: assert property (take |=> queueRdPop && queueRdIdx == $past(activeQueue))
		else $error("first pop after select not from old queue");
	a_pop_new_queue: assert property (take |=> ##1 queueRdPop && queueRdIdx == $past(read_select_bus[4:0], 2))
		else $error("second pop after select not from new queue");
	a_active_update: assert property (take |-> ##2 activeQueue == $past(read_select_bus[4:0], 2))
		else $error("selected queue not taken");
	a_foreign_ignored: assert property (read_queue_select_enable && read_select_bus[7:5] != 3'h0 |=> $stable(activeQueue))
		else $error("select for another device changed queue");
	a_data_follow: assert property (queueRdPop |=> readData == $past(queueRdData))
		else $error("read data not the popped word");
	a_quad_latch: assert property (flag_quadrant_strobe && read_select_bus[7:5] == 3'h0 && !polledMode |-> ##2 almost_empty_flag_bus == ~queueAlmostEmpty[8*$past(read_select_bus[1:0], 2) +: 8])
		else $error("flag bus not the strobed quadrant");
	a_poll_cycle: assert property (polledMode[*6] |-> $countones({flag_bus_sync, $past(flag_bus_sync), $past(flag_bus_sync, 2), $past(flag_bus_sync, 3)}) == 1)
		else $error("sync not once per four clocks");
	a_done_follows: assert property (serial_load_enable_n[*6] |-> serial_done_out_n)
		else $error("done low while load enable high");
	c_take: cover property (take);
	c_strobe: cover property (flag_quadrant_strobe && !polledMode);
	c_sync: cover property (polledMode && flag_bus_sync);
endmodule : mqrp_read_port_checker
bind mqrp_read_port mqrp_read_port_checker u_chk (.core_clk, .rst_n, .read_queue_select_enable,
	.read_select_bus, .flag_quadrant_strobe, .polledMode, .serial_load_enable_n, .queueAlmostEmpty,
	.queueRdData, .queueRdIdx, .queueRdPop, .readData, .almost_empty_flag_bus, .flag_bus_sync,
	.serial_done_out_n, .activeQueue);
`default_nettype wire

// [mqrp_queue_model.sv]
// Queue storage stand-in: answers the indexed queue's head word at once.
// Assumes one pop per clock at most; no queue ever runs empty.
`timescale 1ns/100ps
`default_nettype none
module mqrp_queue_model (
	input  wire logic                        core_clk,
	input  wire logic                        rst_n,
	input  wire logic [mqrp_pkg::QSEL_W-1:0] queueRdIdx,
	input  wire logic                        queueRdPop,
	output logic [mqrp_pkg::DATA_W-1:0]      queueRdData
);
	// Queue number in the top bits shows where a word came from
	logic [12:0] headCount [mqrp_pkg::QUEUES];
	assign queueRdData = {queueRdIdx, headCount[queueRdIdx]};
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			headCount <= '{default: '0};
		end else if (queueRdPop) begin
			headCount[queueRdIdx] <= headCount[queueRdIdx] + 13'h1;
		end
	end
endmodule : mqrp_queue_model
`default_nettype wire

// [multiqueue_read_port_select_bench.sv]
// Self-checking bench for the read-port select block.
// Assumes the queue model as far side; device id loaded as eight zero bits.
`timescale 1ns/100ps
`default_nettype none
module multiqueue_read_port_select_bench;
	logic        core_clk, rst_n, serialClk, serialIn, serial_load_enable_n, polledMode;
	logic        read_queue_select_enable, flag_quadrant_strobe, readStrobe_n, queueRdPop;
	logic        output_valid_n, flag_bus_sync, serial_done_out_n;
	logic [7:0]  read_select_bus, almost_empty_flag_bus;
	logic [31:0] queueAlmostEmpty;
	logic [17:0] queueRdData, readData;
	logic [4:0]  queueRdIdx, activeQueue;
	int          mismatches = 0, check_count = 0, n;
	logic [7:0]  rowSel [6] = '{8'h03, 8'h3F, 8'h1F, 8'hE0, 8'h0A, 8'h00};
	logic [4:0]  rowQ [6] = '{5'h03, 5'h03, 5'h1F, 5'h1F, 5'h0A, 5'h00};
	mqrp_read_port dut (.core_clk, .rst_n, .serialMode(1'b1), .serialClk, .serialIn,
		.serial_load_enable_n, .read_queue_select_enable, .read_select_bus, .flag_quadrant_strobe,
		.readStrobe_n, .polledMode, .expansion_token_in(1'b0), .queueEmpty(32'h0000_0000),
		.queueAlmostEmpty, .queueRdData, .queueRdIdx, .queueRdPop, .readData, .output_valid_n,
		.almost_empty_flag_n(), .almost_empty_flag_bus, .flag_bus_sync, .expansion_token_out(),
		.serial_done_out_n, .activeQueue);
	mqrp_queue_model model (.core_clk, .rst_n, .queueRdIdx, .queueRdPop, .queueRdData);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, want, seen);
		end
	endtask : check
	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task automatic step(input int cycles);
		repeat (cycles) @(posedge core_clk);
		#10;
	endtask : step
	// Strobe held one cycle only: a permanently high enable is not allowed
	task automatic pulse(input logic [7:0] sel, input logic quad);
		read_select_bus = sel;
		if (quad) flag_quadrant_strobe = 1'b1;
		else read_queue_select_enable = 1'b1;
		step(1);
		flag_quadrant_strobe = 1'b0;
		read_queue_select_enable = 1'b0;
		step(3);
	endtask : pulse
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		repeat (5000) @(posedge core_clk);
		mismatches++;
		print_verdict();
	end
	initial begin
		{rst_n, serialClk, serialIn, read_queue_select_enable, flag_quadrant_strobe, polledMode} = '0;
		{serial_load_enable_n, readStrobe_n} = 2'h3;
		read_select_bus = 8'h00;
		queueAlmostEmpty = 32'h8421_C3A5;
		repeat (12) @(posedge core_clk);
		#10 rst_n = 1'b1;
		pulse(8'h05, 1'b0);
		check("queue before done", activeQueue, 5'h00);
		$display("test early select done");
		serial_load_enable_n = 1'b0;
		repeat (8) begin
			serialClk = 1'b1;
			step(4);
			serialClk = 1'b0;
			step(4);
		end
		for (n = 0; n < 50 && serial_done_out_n !== 1'b0; n++) step(1);
		check("programming done", serial_done_out_n, 1'b0);
		if (serial_done_out_n !== 1'b0) print_verdict();
		$display("test programming done");
		for (int i = 0; i < 6; i++) begin
			pulse(rowSel[i], 1'b0);
			check("active queue", activeQueue, rowQ[i]);
			check("data queue", readData[17:13], rowQ[i]);
		end
		$display("test queue rows done");
		readStrobe_n = 1'b0;
		step(4);
		readStrobe_n = 1'b1;
		step(2);
		check("read word", readData, {5'h00, model.headCount[0] - 13'h1});
		check("output valid", output_valid_n, 1'b0);
		$display("test strobed read done");
		for (int q = 0; q < 4; q++) begin
			pulse({6'h07, q[1:0]}, 1'b1);
			check("quadrant flags", almost_empty_flag_bus, {~queueAlmostEmpty[8*q +: 8]});
		end
		$display("test direct flags done");
		polledMode = 1'b1;
		step(4);
		n = 0;
		repeat (8) begin
			if (flag_bus_sync === 1'b1) n++;
			step(1);
		end
		check("sync pulses", n, 2);
		$display("test polled flags done");
		serial_load_enable_n = 1'b1;
		step(8);
		check("done released", serial_done_out_n, 1'b1);
		$display("test done release done");
		print_verdict();
	end
endmodule : multiqueue_read_port_select_bench
`default_nettype wire
